// [sector_protect_cmd_fsm.sv]
// command-decoding state machine for sector protection and unlock-bypass modes
`default_nettype none
module sector_protect_cmd_fsm #(
    parameter int ADDR_W   = 22,
    parameter int SECTOR_W = 7
) (
    input  wire logic                REF_CLK,
    input  wire logic                RST,
    input  wire logic                ENTER_STB,
    input  wire logic [1:0]          ENTER_SEL,
    input  wire logic                WR_STB,
    input  wire logic [ADDR_W-1:0]   WR_ADDR,
    input  wire logic [7:0]          WR_DATA,
    input  wire logic                LOCK_REG_BIT3,
    input  wire logic                STATUS_DONE_BIT,
    input  wire logic                OP_OK,
    input  wire logic                BYPASS_SUB_DONE,
    output logic [4:0]               STATE,
    output logic                     PERSIST_PROG_GO,
    output logic                     PERSIST_ERASE_GO,
    output logic                     LOCKBIT_SET_GO,
    output logic                     VOLATILE_SET_GO,
    output logic                     VOLATILE_CLR_GO,
    output logic [SECTOR_W-1:0]      SECTOR_OUT,
    output logic                     RETURN_PRIOR,
    output logic                     RETURN_READ
);
    // ========================================
    // write decode
    sector_protect_pkg::prot_state_e state_r;
    sector_protect_pkg::prot_state_e state_nxt;
    logic                            is_reset;
    logic                            is_sr_read;
    logic                            is_sr_clear;
    logic                            at_zero;
    logic                            hang;
    logic                            done_ok;
    logic [SECTOR_W-1:0]             sector_in;
    logic                            prog_go_nxt;
    logic                            erase_go_nxt;
    logic                            lock_go_nxt;
    logic                            vset_go_nxt;
    logic                            vclr_go_nxt;
    logic                            ret_prior_nxt;
    logic                            ret_read_nxt;

    assign sector_in   = WR_ADDR[ADDR_W-1 -: SECTOR_W];
    assign is_reset    = WR_STB && (WR_DATA == sector_protect_pkg::CMD_SW_RESET);
    assign is_sr_read  = WR_STB && (WR_DATA == sector_protect_pkg::CMD_SR_READ)
                         && (WR_ADDR[sector_protect_pkg::UNLOCK_BITS-1:0] == sector_protect_pkg::ADDR_UNLOCK);
    assign is_sr_clear = WR_STB && (WR_DATA == sector_protect_pkg::CMD_SR_CLEAR)
                         && (WR_ADDR[sector_protect_pkg::UNLOCK_BITS-1:0] == sector_protect_pkg::ADDR_UNLOCK);
    assign at_zero     = (WR_ADDR == '0);
    // a finished operation wins over a stale done bit; only a done without ok is a hang
    assign done_ok     = OP_OK;
    assign hang        = STATUS_DONE_BIT && !OP_OK;

    // ========================================
    // next state and command pulses
    always_comb begin
        state_nxt     = state_r;
        prog_go_nxt   = 1'b0;
        erase_go_nxt  = 1'b0;
        lock_go_nxt   = 1'b0;
        vset_go_nxt   = 1'b0;
        vclr_go_nxt   = 1'b0;
        ret_prior_nxt = 1'b0;
        ret_read_nxt  = 1'b0;
        // any command not listed below leaves the state unchanged; unlisted state codes go to ST_IDLE
        case (state_r)
            sector_protect_pkg::ST_IDLE: begin
                if (ENTER_STB) begin
                    case (ENTER_SEL)
                        sector_protect_pkg::ENTER_PERSIST:  state_nxt = sector_protect_pkg::ST_PERSIST_MODE;
                        sector_protect_pkg::ENTER_LOCKBIT:  state_nxt = sector_protect_pkg::ST_LOCKBIT_MODE;
                        sector_protect_pkg::ENTER_VOLATILE: state_nxt = sector_protect_pkg::ST_VOLATILE_MODE;
                        default:                            state_nxt = sector_protect_pkg::ST_BYPASS_MODE;
                    endcase
                end
            end
            sector_protect_pkg::ST_PERSIST_MODE: begin
                if (is_reset) begin
                    state_nxt     = sector_protect_pkg::ST_IDLE;
                    ret_prior_nxt = 1'b1;
                end else if (is_sr_read || is_sr_clear) begin
                    state_nxt = sector_protect_pkg::ST_PERSIST_MODE;
                end else if (WR_STB && WR_DATA == sector_protect_pkg::CMD_EXIT_ENTRY) begin
                    state_nxt = sector_protect_pkg::ST_PERSIST_EXIT_PENDING;
                end else if (WR_STB && WR_DATA == sector_protect_pkg::CMD_PROG_ENTRY) begin
                    state_nxt = sector_protect_pkg::ST_PERSIST_PROG_ARMED;
                end else if (WR_STB && WR_DATA == sector_protect_pkg::CMD_ERASE_ENT && LOCK_REG_BIT3) begin
                    state_nxt = sector_protect_pkg::ST_PERSIST_ERASE_ARMED;
                end
            end
            sector_protect_pkg::ST_PERSIST_PROG_ARMED: begin
                if (is_reset) begin
                    state_nxt = sector_protect_pkg::ST_PERSIST_MODE;
                end else if (WR_STB && WR_DATA == sector_protect_pkg::CMD_SET) begin
                    state_nxt   = sector_protect_pkg::ST_PERSIST_PROG_BUSY;
                    prog_go_nxt = 1'b1;
                end
            end
            sector_protect_pkg::ST_PERSIST_ERASE_ARMED: begin
                if (is_reset || is_sr_read) begin
                    state_nxt = sector_protect_pkg::ST_PERSIST_MODE;
                end else if (WR_STB && WR_DATA == sector_protect_pkg::CMD_ERASE_GO && at_zero) begin
                    state_nxt    = sector_protect_pkg::ST_PERSIST_ERASE_BUSY;
                    erase_go_nxt = 1'b1;
                end
            end
            sector_protect_pkg::ST_PERSIST_PROG_BUSY,
            sector_protect_pkg::ST_PERSIST_ERASE_BUSY: begin
                if (done_ok) begin
                    state_nxt = sector_protect_pkg::ST_PERSIST_MODE;
                end else if (hang && is_reset) begin
                    state_nxt = sector_protect_pkg::ST_PERSIST_MODE;
                end
            end
            sector_protect_pkg::ST_PERSIST_EXIT_PENDING: begin
                if (WR_STB && WR_DATA == sector_protect_pkg::CMD_EXIT) begin
                    state_nxt     = sector_protect_pkg::ST_IDLE;
                    ret_prior_nxt = 1'b1;
                end
            end
            sector_protect_pkg::ST_LOCKBIT_MODE: begin
                if (is_reset) begin
                    state_nxt    = sector_protect_pkg::ST_IDLE;
                    ret_read_nxt = 1'b1;
                end else if (is_sr_read) begin
                    state_nxt = sector_protect_pkg::ST_LOCKBIT_MODE;
                end else if (WR_STB && WR_DATA == sector_protect_pkg::CMD_EXIT_ENTRY) begin
                    state_nxt = sector_protect_pkg::ST_LOCKBIT_EXIT_PENDING;
                end else if (WR_STB && WR_DATA == sector_protect_pkg::CMD_PROG_ENTRY) begin
                    state_nxt = sector_protect_pkg::ST_LOCKBIT_SET_ARMED;
                end
            end
            sector_protect_pkg::ST_LOCKBIT_SET_ARMED: begin
                // the exit byte equals the set byte; here it is only ever set data
                if (WR_STB && WR_DATA == sector_protect_pkg::CMD_SET) begin
                    state_nxt   = sector_protect_pkg::ST_LOCKBIT_MODE;
                    lock_go_nxt = 1'b1;
                end
            end
            sector_protect_pkg::ST_LOCKBIT_EXIT_PENDING: begin
                if (WR_STB && WR_DATA == sector_protect_pkg::CMD_EXIT) begin
                    state_nxt    = sector_protect_pkg::ST_IDLE;
                    ret_read_nxt = 1'b1;
                end
            end
            sector_protect_pkg::ST_VOLATILE_MODE: begin
                if (is_reset) begin
                    state_nxt     = sector_protect_pkg::ST_IDLE;
                    ret_prior_nxt = 1'b1;
                end else if (is_sr_read) begin
                    state_nxt = sector_protect_pkg::ST_VOLATILE_MODE;
                end else if (WR_STB && WR_DATA == sector_protect_pkg::CMD_EXIT_ENTRY) begin
                    state_nxt = sector_protect_pkg::ST_VOLATILE_EXIT_PENDING;
                end else if (WR_STB && WR_DATA == sector_protect_pkg::CMD_PROG_ENTRY) begin
                    state_nxt = sector_protect_pkg::ST_VOLATILE_CMD_ARMED;
                end
            end
            sector_protect_pkg::ST_VOLATILE_CMD_ARMED: begin
                if (WR_STB && WR_DATA == sector_protect_pkg::CMD_SET) begin
                    state_nxt   = sector_protect_pkg::ST_VOLATILE_MODE;
                    vset_go_nxt = 1'b1;
                end else if (WR_STB && WR_DATA == sector_protect_pkg::CMD_CLEAR) begin
                    state_nxt   = sector_protect_pkg::ST_VOLATILE_MODE;
                    vclr_go_nxt = 1'b1;
                end
            end
            sector_protect_pkg::ST_VOLATILE_EXIT_PENDING: begin
                if (WR_STB && WR_DATA == sector_protect_pkg::CMD_EXIT) begin
                    state_nxt     = sector_protect_pkg::ST_IDLE;
                    ret_prior_nxt = 1'b1;
                end
            end
            sector_protect_pkg::ST_BYPASS_MODE: begin
                if (WR_STB && WR_DATA == sector_protect_pkg::CMD_PROG_ENTRY) begin
                    state_nxt = sector_protect_pkg::ST_BYPASS_PROG_ARMED;
                end else if (WR_STB && WR_DATA == sector_protect_pkg::CMD_BUF_LOAD) begin
                    state_nxt = sector_protect_pkg::ST_BYPASS_BUFFER_LOAD;
                end else if (WR_STB && WR_DATA == sector_protect_pkg::CMD_ERASE_ENT) begin
                    state_nxt = sector_protect_pkg::ST_BYPASS_ERASE_ARMED;
                end else if (WR_STB && WR_DATA == sector_protect_pkg::CMD_EXIT_ENTRY) begin
                    state_nxt = sector_protect_pkg::ST_BYPASS_EXIT_PENDING;
                end
            end
            sector_protect_pkg::ST_BYPASS_PROG_ARMED,
            sector_protect_pkg::ST_BYPASS_BUFFER_LOAD,
            sector_protect_pkg::ST_BYPASS_ERASE_ARMED: begin
                // sub-machines live elsewhere; they hand control back when finished
                if (BYPASS_SUB_DONE) begin
                    state_nxt = sector_protect_pkg::ST_BYPASS_MODE;
                end
            end
            sector_protect_pkg::ST_BYPASS_EXIT_PENDING: begin
                if (WR_STB && WR_DATA == sector_protect_pkg::CMD_EXIT) begin
                    state_nxt    = sector_protect_pkg::ST_IDLE;
                    ret_read_nxt = 1'b1;
                end
            end
            default: begin
                state_nxt = sector_protect_pkg::ST_IDLE;
            end
        endcase
    end

    // ========================================
    // state register
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            state_r <= sector_protect_pkg::prot_state_e'(sector_protect_pkg::STATE_RESET);
        end else begin
            state_r <= state_nxt;
        end
    end

    assign STATE = state_r;

    // ========================================
    // registered command pulses toward the protection array
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            PERSIST_PROG_GO  <= 1'b0;
            PERSIST_ERASE_GO <= 1'b0;
            LOCKBIT_SET_GO   <= 1'b0;
            VOLATILE_SET_GO  <= 1'b0;
            VOLATILE_CLR_GO  <= 1'b0;
            RETURN_PRIOR     <= 1'b0;
            RETURN_READ      <= 1'b0;
        end else begin
            PERSIST_PROG_GO  <= prog_go_nxt;
            PERSIST_ERASE_GO <= erase_go_nxt;
            LOCKBIT_SET_GO   <= lock_go_nxt;
            VOLATILE_SET_GO  <= vset_go_nxt;
            VOLATILE_CLR_GO  <= vclr_go_nxt;
            RETURN_PRIOR     <= ret_prior_nxt;
            RETURN_READ      <= ret_read_nxt;
        end
    end

    // sector captured only with a bit command so it stays valid past the pulse
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            SECTOR_OUT <= '0;
        end else if (prog_go_nxt || vset_go_nxt || vclr_go_nxt) begin
            SECTOR_OUT <= sector_in;
        end
    end

    // ========================================
    // checks
    a_erase_start: assert property (@(posedge REF_CLK) disable iff (RST)
        (state_r == sector_protect_pkg::ST_PERSIST_ERASE_ARMED && WR_STB
         && WR_DATA == 8'h30 && WR_ADDR == '0)
        |=> (state_r == sector_protect_pkg::ST_PERSIST_ERASE_BUSY) && PERSIST_ERASE_GO)
        else $error("erase start not taken");
    a_erase_gate: assert property (@(posedge REF_CLK) disable iff (RST)
        (state_r == sector_protect_pkg::ST_PERSIST_MODE && WR_STB && WR_DATA == 8'h80 && !LOCK_REG_BIT3)
        |=> state_r == sector_protect_pkg::ST_PERSIST_MODE)
        else $error("erase entry accepted with lock bit clear");
    a_hang_only_reset: assert property (@(posedge REF_CLK) disable iff (RST)
        ((state_r == sector_protect_pkg::ST_PERSIST_PROG_BUSY
          || state_r == sector_protect_pkg::ST_PERSIST_ERASE_BUSY) && STATUS_DONE_BIT && !OP_OK)
        |=> (state_r == $past(state_r)) != ($past(WR_STB) && $past(WR_DATA) == 8'hF0))
        else $error("hang state left by other than reset");
    a_busy_return: assert property (@(posedge REF_CLK) disable iff (RST)
        ((state_r == sector_protect_pkg::ST_PERSIST_PROG_BUSY
          || state_r == sector_protect_pkg::ST_PERSIST_ERASE_BUSY) && OP_OK)
        |=> state_r == sector_protect_pkg::ST_PERSIST_MODE)
        else $error("busy did not return after completion");
    a_persist_exit: assert property (@(posedge REF_CLK) disable iff (RST)
        (state_r == sector_protect_pkg::ST_PERSIST_EXIT_PENDING && WR_STB && WR_DATA != 8'h00)
        |=> state_r == sector_protect_pkg::ST_PERSIST_EXIT_PENDING && !RETURN_PRIOR)
        else $error("exit pending left by other command");
    a_lockbit_set: assert property (@(posedge REF_CLK) disable iff (RST)
        (state_r == sector_protect_pkg::ST_LOCKBIT_SET_ARMED && WR_STB && WR_DATA == 8'h00)
        |=> LOCKBIT_SET_GO && !RETURN_READ ##1 !LOCKBIT_SET_GO)
        else $error("lock bit set misbehaved");
    a_lockbit_exit: assert property (@(posedge REF_CLK) disable iff (RST)
        (state_r == sector_protect_pkg::ST_LOCKBIT_EXIT_PENDING && WR_STB && WR_DATA == 8'h00)
        |=> RETURN_READ && state_r == sector_protect_pkg::ST_IDLE)
        else $error("lock bit exit not to read");
    a_vol_sector: assert property (@(posedge REF_CLK) disable iff (RST)
        (state_r == sector_protect_pkg::ST_VOLATILE_CMD_ARMED && WR_STB && WR_DATA == 8'h01)
        |=> VOLATILE_CLR_GO && !VOLATILE_SET_GO && SECTOR_OUT == $past(sector_in)
            && state_r == sector_protect_pkg::ST_VOLATILE_MODE)
        else $error("volatile clear wrong");
    a_bypass_exit: assert property (@(posedge REF_CLK) disable iff (RST)
        (state_r == sector_protect_pkg::ST_BYPASS_EXIT_PENDING && WR_STB && WR_DATA == 8'h00)
        |=> RETURN_READ && !RETURN_PRIOR)
        else $error("bypass exit not to read");
    a_no_stray_go: assert property (@(posedge REF_CLK) disable iff (RST)
        !WR_STB |=> !(PERSIST_PROG_GO || PERSIST_ERASE_GO || LOCKBIT_SET_GO
                      || VOLATILE_SET_GO || VOLATILE_CLR_GO))
        else $error("protection change without a write");
    a_prog_start: assert property (@(posedge REF_CLK) disable iff (RST)
        (state_r == sector_protect_pkg::ST_PERSIST_PROG_ARMED && WR_STB && WR_DATA == sector_protect_pkg::CMD_SET)
        |=> state_r == sector_protect_pkg::ST_PERSIST_PROG_BUSY && PERSIST_PROG_GO && SECTOR_OUT == $past(sector_in))
        else $error("persistent bit program not started");
    a_vol_set: assert property (@(posedge REF_CLK) disable iff (RST)
        (state_r == sector_protect_pkg::ST_VOLATILE_CMD_ARMED && WR_STB && WR_DATA == sector_protect_pkg::CMD_SET)
        |=> VOLATILE_SET_GO && !VOLATILE_CLR_GO && state_r == sector_protect_pkg::ST_VOLATILE_MODE)
        else $error("volatile set wrong");
    a_vol_exit: assert property (@(posedge REF_CLK) disable iff (RST)
        (state_r == sector_protect_pkg::ST_VOLATILE_EXIT_PENDING && WR_STB && WR_DATA == sector_protect_pkg::CMD_EXIT)
        |=> RETURN_PRIOR && !RETURN_READ && state_r == sector_protect_pkg::ST_IDLE)
        else $error("volatile exit not to prior state");
    a_bypass_leave: assert property (@(posedge REF_CLK) disable iff (RST)
        (state_r == sector_protect_pkg::ST_BYPASS_MODE && WR_STB && WR_DATA == sector_protect_pkg::CMD_EXIT_ENTRY)
        |=> state_r == sector_protect_pkg::ST_BYPASS_EXIT_PENDING)
        else $error("bypass exit entry not taken");
endmodule
`default_nettype wire

// [sector_protect_pkg.sv]
// constants, command codes and state encoding for the protection command machine
`default_nettype none
package sector_protect_pkg;
    // ========================================
    // command data bytes
    localparam logic [7:0] CMD_SW_RESET   = 8'hF0;
    localparam logic [7:0] CMD_SR_READ    = 8'h70;
    localparam logic [7:0] CMD_SR_CLEAR   = 8'h71;
    localparam logic [7:0] CMD_EXIT_ENTRY = 8'h90;
    localparam logic [7:0] CMD_EXIT       = 8'h00;
    localparam logic [7:0] CMD_PROG_ENTRY = 8'hA0;
    localparam logic [7:0] CMD_SET        = 8'h00;
    localparam logic [7:0] CMD_CLEAR      = 8'h01;
    localparam logic [7:0] CMD_ERASE_ENT  = 8'h80;
    localparam logic [7:0] CMD_ERASE_GO   = 8'h30;
    localparam logic [7:0] CMD_BUF_LOAD   = 8'h25;
    // ========================================
    // command addresses (low address bits)
    localparam logic [11:0] ADDR_UNLOCK   = 12'h555;
    localparam logic [11:0] ADDR_ZERO     = 12'h000;
    localparam int          UNLOCK_BITS   = 12;
    // ========================================
    // entry selector codes
    localparam logic [1:0] ENTER_PERSIST  = 2'h0;
    localparam logic [1:0] ENTER_LOCKBIT  = 2'h1;
    localparam logic [1:0] ENTER_VOLATILE = 2'h2;
    localparam logic [1:0] ENTER_BYPASS   = 2'h3;
    // ========================================
    // machine states
    typedef enum logic [4:0] {
        ST_IDLE,
        ST_PERSIST_MODE,
        ST_PERSIST_PROG_ARMED,
        ST_PERSIST_PROG_BUSY,
        ST_PERSIST_ERASE_ARMED,
        ST_PERSIST_ERASE_BUSY,
        ST_PERSIST_EXIT_PENDING,
        ST_LOCKBIT_MODE,
        ST_LOCKBIT_SET_ARMED,
        ST_LOCKBIT_EXIT_PENDING,
        ST_VOLATILE_MODE,
        ST_VOLATILE_CMD_ARMED,
        ST_VOLATILE_EXIT_PENDING,
        ST_BYPASS_MODE,
        ST_BYPASS_PROG_ARMED,
        ST_BYPASS_BUFFER_LOAD,
        ST_BYPASS_ERASE_ARMED,
        ST_BYPASS_EXIT_PENDING
    } prot_state_e;
    localparam logic [4:0] STATE_RESET = 5'h00;
endpackage
`default_nettype wire

// [host_cmd_model.sv]
// host-side bus model issuing single command write cycles
`default_nettype none
module host_cmd_model #(
    parameter int ADDR_W = 22
) (
    input  wire logic              ref_clk,
    output logic                   wr_stb,
    output logic [ADDR_W-1:0]      wr_addr,
    output logic [7:0]             wr_data
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        wr_stb  = 1'b0;
        wr_addr = '0;
        wr_data = 8'h00;
    end
    // ========================================
    // one write cycle; lines scrambled after release so stale values never look valid
    task automatic write(input logic [ADDR_W-1:0] addr, input logic [7:0] data);
        @(posedge ref_clk);
        #1;
        wr_stb  = 1'b1;
        wr_addr = addr;
        wr_data = data;
        @(posedge ref_clk);
        #1;
        wr_stb  = 1'b0;
        wr_addr = ~addr;
        wr_data = ~data;
    endtask
endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench for the protection command machine
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int ADDR_W = 22;
    localparam logic [7:0] P_PROG = 8'h40, P_ERASE = 8'h20, P_LB = 8'h10, P_VSET = 8'h08;
    localparam logic [7:0] P_VCLR = 8'h04, P_PRIOR = 8'h02, P_READ = 8'h01;
    logic              ref_clk = 1'b0;
    logic              rst = 1'b1;
    logic              enter_stb = 1'b0;
    logic [1:0]        enter_sel = 2'h0;
    logic              lock_bit3 = 1'b0;
    logic              status_done = 1'b0;
    logic              op_ok = 1'b0;
    logic              sub_done = 1'b0;
    logic              wr_stb;
    logic [ADDR_W-1:0] wr_addr;
    logic [7:0]        wr_data;
    logic [4:0]        state;
    logic              prog_go, erase_go, lb_go, vset_go, vclr_go, ret_prior, ret_read;
    logic [6:0]        sector;
    int                n_fail = 0;
    int                total_checks = 0;
    int                cyc = 0;
    always #20 ref_clk = ~ref_clk;
    host_cmd_model #(.ADDR_W(ADDR_W)) i_host_cmd_model (.ref_clk(ref_clk), .wr_stb(wr_stb), .wr_addr(wr_addr),
        .wr_data(wr_data));
    sector_protect_cmd_fsm i_sector_protect_cmd_fsm (.REF_CLK(ref_clk), .RST(rst), .ENTER_STB(enter_stb),
        .ENTER_SEL(enter_sel), .WR_STB(wr_stb), .WR_ADDR(wr_addr), .WR_DATA(wr_data), .LOCK_REG_BIT3(lock_bit3),
        .STATUS_DONE_BIT(status_done), .OP_OK(op_ok), .BYPASS_SUB_DONE(sub_done), .STATE(state),
        .PERSIST_PROG_GO(prog_go), .PERSIST_ERASE_GO(erase_go), .LOCKBIT_SET_GO(lb_go),
        .VOLATILE_SET_GO(vset_go), .VOLATILE_CLR_GO(vclr_go), .SECTOR_OUT(sector), .RETURN_PRIOR(ret_prior),
        .RETURN_READ(ret_read));
    // ========================================
    // shared checking and stimulus
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ceiling well above the roughly 110 cycles the tests need
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic expect_out(input sector_protect_pkg::prot_state_e st, input logic [7:0] pl);
        check("state", {3'h0, state}, {3'h0, st});
        check("pulses", {1'b0, prog_go, erase_go, lb_go, vset_go, vclr_go, ret_prior, ret_read}, pl);
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input sector_protect_pkg::prot_state_e st,
                      input logic [7:0] pl);
        i_host_cmd_model.write(a, d);
        expect_out(st, pl);
    endtask
    // k: bit0 mode entry, bit1 normal completion, bit2 bypass sub-machine return
    task automatic evt(input logic [2:0] k, input logic [1:0] sel, input sector_protect_pkg::prot_state_e st);
        @(posedge ref_clk);
        #1;
        {sub_done, op_ok, enter_stb} = k;
        enter_sel = sel;
        @(posedge ref_clk);
        #1;
        {sub_done, op_ok, enter_stb} = 3'h0;
        expect_out(st, 8'h00);
    endtask
    // ========================================
    // scenarios
    task automatic t_persist();
        lock_bit3 = 1'b0;
        evt(3'h1, sector_protect_pkg::ENTER_PERSIST, sector_protect_pkg::ST_PERSIST_MODE);
        wr(22'h000555, 8'h70, sector_protect_pkg::ST_PERSIST_MODE, 8'h00);
        wr(22'h000555, 8'h71, sector_protect_pkg::ST_PERSIST_MODE, 8'h00);
        wr(22'h000123, 8'h80, sector_protect_pkg::ST_PERSIST_MODE, 8'h00);
        wr(22'h000001, 8'hA0, sector_protect_pkg::ST_PERSIST_PROG_ARMED, 8'h00);
        wr({7'h7F, 15'h0000}, 8'h00, sector_protect_pkg::ST_PERSIST_PROG_BUSY, P_PROG);
        check("sector", {1'b0, sector}, 8'h7F);
        evt(3'h2, 2'h0, sector_protect_pkg::ST_PERSIST_MODE);
        wr(22'h3FFFFF, 8'h90, sector_protect_pkg::ST_PERSIST_EXIT_PENDING, 8'h00);
        wr(22'h000555, 8'h70, sector_protect_pkg::ST_PERSIST_EXIT_PENDING, 8'h00);
        wr(22'h000000, 8'h00, sector_protect_pkg::ST_IDLE, P_PRIOR);
        $display("test persist done");
    endtask
    task automatic t_erase_hang();
        lock_bit3 = 1'b1;
        evt(3'h1, sector_protect_pkg::ENTER_PERSIST, sector_protect_pkg::ST_PERSIST_MODE);
        wr(22'h2AAAAA, 8'h80, sector_protect_pkg::ST_PERSIST_ERASE_ARMED, 8'h00);
        wr(22'h000001, 8'h30, sector_protect_pkg::ST_PERSIST_ERASE_ARMED, 8'h00);
        wr(22'h000000, 8'h30, sector_protect_pkg::ST_PERSIST_ERASE_BUSY, P_ERASE);
        status_done = 1'b1;
        wr(22'h000000, 8'hA0, sector_protect_pkg::ST_PERSIST_ERASE_BUSY, 8'h00);
        wr(22'h000000, 8'hF0, sector_protect_pkg::ST_PERSIST_MODE, 8'h00);
        status_done = 1'b0;
        wr(22'h000000, 8'hA0, sector_protect_pkg::ST_PERSIST_PROG_ARMED, 8'h00);
        wr(22'h000000, 8'hF0, sector_protect_pkg::ST_PERSIST_MODE, 8'h00);
        wr(22'h000000, 8'h80, sector_protect_pkg::ST_PERSIST_ERASE_ARMED, 8'h00);
        wr(22'h000555, 8'h70, sector_protect_pkg::ST_PERSIST_MODE, 8'h00);
        wr(22'h000000, 8'hF0, sector_protect_pkg::ST_IDLE, P_PRIOR);
        $display("test erase and hang done");
    endtask
    task automatic t_lockbit();
        evt(3'h1, sector_protect_pkg::ENTER_LOCKBIT, sector_protect_pkg::ST_LOCKBIT_MODE);
        wr(22'h000555, 8'h70, sector_protect_pkg::ST_LOCKBIT_MODE, 8'h00);
        wr(22'h000000, 8'hA0, sector_protect_pkg::ST_LOCKBIT_SET_ARMED, 8'h00);
        wr(22'h000000, 8'h00, sector_protect_pkg::ST_LOCKBIT_MODE, P_LB);
        wr(22'h000000, 8'h90, sector_protect_pkg::ST_LOCKBIT_EXIT_PENDING, 8'h00);
        wr(22'h000000, 8'h00, sector_protect_pkg::ST_IDLE, P_READ);
        evt(3'h1, sector_protect_pkg::ENTER_LOCKBIT, sector_protect_pkg::ST_LOCKBIT_MODE);
        wr(22'h000000, 8'hF0, sector_protect_pkg::ST_IDLE, P_READ);
        $display("test lock bit done");
    endtask
    task automatic t_volatile();
        evt(3'h1, sector_protect_pkg::ENTER_VOLATILE, sector_protect_pkg::ST_VOLATILE_MODE);
        wr(22'h000555, 8'h70, sector_protect_pkg::ST_VOLATILE_MODE, 8'h00);
        wr(22'h000000, 8'hA0, sector_protect_pkg::ST_VOLATILE_CMD_ARMED, 8'h00);
        wr({7'h01, 15'h0000}, 8'h01, sector_protect_pkg::ST_VOLATILE_MODE, P_VCLR);
        check("sector", {1'b0, sector}, 8'h01);
        wr(22'h000000, 8'hA0, sector_protect_pkg::ST_VOLATILE_CMD_ARMED, 8'h00);
        wr({7'h7E, 15'h0000}, 8'h00, sector_protect_pkg::ST_VOLATILE_MODE, P_VSET);
        check("sector", {1'b0, sector}, 8'h7E);
        wr(22'h000000, 8'h90, sector_protect_pkg::ST_VOLATILE_EXIT_PENDING, 8'h00);
        wr(22'h000000, 8'h01, sector_protect_pkg::ST_VOLATILE_EXIT_PENDING, 8'h00);
        wr(22'h1234AB, 8'h00, sector_protect_pkg::ST_IDLE, P_PRIOR);
        evt(3'h1, sector_protect_pkg::ENTER_VOLATILE, sector_protect_pkg::ST_VOLATILE_MODE);
        wr(22'h000000, 8'hF0, sector_protect_pkg::ST_IDLE, P_PRIOR);
        $display("test volatile done");
    endtask
    task automatic t_bypass();
        logic [7:0] cmds[3] = '{8'hA0, 8'h25, 8'h80};
        sector_protect_pkg::prot_state_e sts[3] = '{sector_protect_pkg::ST_BYPASS_PROG_ARMED,
            sector_protect_pkg::ST_BYPASS_BUFFER_LOAD, sector_protect_pkg::ST_BYPASS_ERASE_ARMED};
        evt(3'h1, sector_protect_pkg::ENTER_BYPASS, sector_protect_pkg::ST_BYPASS_MODE);
        wr(22'h000000, 8'hF0, sector_protect_pkg::ST_BYPASS_MODE, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wr(22'h000000, cmds[i], sts[i], 8'h00);
            evt(3'h4, 2'h0, sector_protect_pkg::ST_BYPASS_MODE);
        end
        wr(22'h000000, 8'h90, sector_protect_pkg::ST_BYPASS_EXIT_PENDING, 8'h00);
        wr(22'h000000, 8'hA0, sector_protect_pkg::ST_BYPASS_EXIT_PENDING, 8'h00);
        wr(22'h3FFFFF, 8'h00, sector_protect_pkg::ST_IDLE, P_READ);
        $display("test bypass done");
    endtask
    // ========================================
    // main sequence
    initial begin
        repeat (12) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        expect_out(sector_protect_pkg::ST_IDLE, 8'h00);
        check("sector", {1'b0, sector}, 8'h00);
        t_persist();
        t_erase_hang();
        t_lockbit();
        t_volatile();
        t_bypass();
        give_verdict();
    end
endmodule
`default_nettype wire
